// File: rtl/mcsc_cfg.svh
// Function
// - Thirty-two semaphores, acquire marks one held
// - Release returns named semaphore to free
// - Acquire succeeds only when semaphore free (here an owner re-acquiring its held semaphore is also reported done)
// - Held semaphore denied to all others
// - Successful release clears semaphore storage byte
// - Only owning CPU may release
// - Request samples state before deciding change
// - Result: 00 denied, 10 success
// - Check and update are one indivisible step
// - One global instance of each semaphore
// - Cold restart clears all semaphores
// - Warm restart keeps semaphore states
// - Each CPU must itself acquire and release
// - CPUs sharing an area agree one number
// - All CPUs perform same restart kind
`ifndef MCSC_CFG_SVH
`define MCSC_CFG_SVH
`define MCSC_NUM_CPU 4
`define MCSC_CPU_W 2
`define MCSC_NUM_SEM 32
`define MCSC_SEM_W 5
`define MCSC_BYTE_HELD 8'hFF
`define MCSC_BYTE_FREE 8'h00
`define MCSC_RES_DENIED 2'h0
`define MCSC_RES_DONE 2'h2
`endif

// File: rtl/mcsc_pkg.sv
`include "mcsc_cfg.svh"
package mcsc_pkg;
	typedef logic [`MCSC_SEM_W-1:0] mcsc_sem_t;
	typedef logic [`MCSC_CPU_W-1:0] mcsc_cpu_t;
	typedef logic [1:0] mcsc_res_t;
	typedef enum logic {
		MCSC_OP_RELEASE,
		MCSC_OP_ACQUIRE
	} mcsc_op_e;
endpackage

// File: rtl/mcsc_if.sv
`include "mcsc_cfg.svh"
interface mcsc_if (
	input wire logic clock,
	input wire logic rst_n
);
	logic [`MCSC_NUM_CPU-1:0] req_valid;
	mcsc_pkg::mcsc_op_e req_op [`MCSC_NUM_CPU];
	mcsc_pkg::mcsc_sem_t req_sem [`MCSC_NUM_CPU];
	logic [`MCSC_NUM_CPU-1:0] rsp_valid;
	mcsc_pkg::mcsc_res_t rsp_result [`MCSC_NUM_CPU];
	logic cold_restart;
	modport coord (
		input clock, rst_n, req_valid, req_op, req_sem, cold_restart,
		output rsp_valid, rsp_result
	);
	modport cpus (
		input clock, rst_n, rsp_valid, rsp_result,
		output req_valid, req_op, req_sem, cold_restart
	);
endinterface

// File: rtl/mcsc_coord.sv
`include "mcsc_cfg.svh"
module mcsc_coord (
	mcsc_if.coord bus,
	output logic [`MCSC_NUM_SEM-1:0] held_map
);
	// One bank of semaphores serves every CPU on the bus. All requests that
	// arrive in one cycle are resolved together by a serial walk in CPU index
	// order, so each request sees the state that the lower CPUs leave behind.
	// The walk reads and writes one private view of the bank, which makes the
	// check and the update of each request a single step that no other CPU
	// can split. Every request outside a cold restart is answered exactly
	// one cycle after it is taken, with done or denied.
	// A cold restart frees the whole bank and refuses every request of that
	// cycle. A warm restart is just the absence of a cold one, so the bank
	// keeps its contents across it.
	// The owner table is not cleared by a cold restart: an owner entry only
	// matters while its byte is held, and a free byte ignores it.

	// Storage bytes, one per semaphore number, shared by all CPUs
	logic [7:0] sem_byte_r [`MCSC_NUM_SEM];
	logic [7:0] sem_byte_nxt [`MCSC_NUM_SEM];
	// Owner of each held semaphore; left stale once the byte is free
	mcsc_pkg::mcsc_cpu_t owner_r [`MCSC_NUM_SEM];
	mcsc_pkg::mcsc_cpu_t owner_nxt [`MCSC_NUM_SEM];
	// One answer per request outside a cold restart, a cycle after it is taken
	logic [`MCSC_NUM_CPU-1:0] rsp_valid_r;
	logic [`MCSC_NUM_CPU-1:0] rsp_valid_nxt;
	mcsc_pkg::mcsc_res_t rsp_result_r [`MCSC_NUM_CPU];
	mcsc_pkg::mcsc_res_t rsp_result_nxt [`MCSC_NUM_CPU];
	// Mirror of the bytes, one bit per semaphore, for the held map
	logic [`MCSC_NUM_SEM-1:0] held_r;
	logic [`MCSC_NUM_SEM-1:0] held_nxt;
	// Outcome of each request after the serial walk below
	logic [`MCSC_NUM_CPU-1:0] req_live;
	logic [`MCSC_NUM_CPU-1:0] req_take;
	logic [`MCSC_NUM_CPU-1:0] req_drop;
	logic [`MCSC_NUM_CPU-1:0] req_done;

	////////////////////////////////////////////////////////////////////////
	// A request counts only outside a cold restart, which is refused whole
	always_comb begin
		req_live = bus.req_valid & {`MCSC_NUM_CPU{~bus.cold_restart}};
	end

	////////////////////////////////////////////////////////////////////////
	// Serial walk: each request samples its semaphore in the private view,
	// decides, and writes the view back before the next CPU looks at it.
	// Lower index wins a same-cycle race for a free semaphore.
	always_comb begin
		logic [`MCSC_NUM_SEM-1:0] view_held;
		mcsc_pkg::mcsc_cpu_t view_owner [`MCSC_NUM_SEM];
		logic busy;
		logic mine;
		view_held = '0;
		for (int s = 0; s < `MCSC_NUM_SEM; s++) begin
			view_held[s] = sem_byte_r[s] != `MCSC_BYTE_FREE;
		end
		view_owner = owner_r;
		busy = 1'h0;
		mine = 1'h0;
		req_take = '0;
		req_drop = '0;
		req_done = '0;
		for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
			if (req_live[c]) begin
				// Sample first, then decide on that sample only
				busy = view_held[bus.req_sem[c]];
				mine = view_owner[bus.req_sem[c]] == c[`MCSC_CPU_W-1:0];
				if (bus.req_op[c] == mcsc_pkg::MCSC_OP_ACQUIRE) begin
					if (!busy) begin
						req_take[c] = 1'h1;
						req_done[c] = 1'h1;
						view_held[bus.req_sem[c]] = 1'h1;
						view_owner[bus.req_sem[c]] = c[`MCSC_CPU_W-1:0];
					end else if (mine) begin
						// Re-acquire by the owner is harmless and reported done
						req_done[c] = 1'h1;
					end
					// Held by another: denied, nothing changes
				end else if (!busy || mine) begin
					// Free or own: release; held by another: left held
					req_drop[c] = 1'h1;
					req_done[c] = 1'h1;
					view_held[bus.req_sem[c]] = 1'h0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Storage bytes; later CPUs in the walk overwrite earlier ones, which
	// matches the order in which the walk saw them
	always_comb begin
		sem_byte_nxt = sem_byte_r;
		for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
			if (req_take[c]) begin
				sem_byte_nxt[bus.req_sem[c]] = `MCSC_BYTE_HELD;
			end
			if (req_drop[c]) begin
				sem_byte_nxt[bus.req_sem[c]] = `MCSC_BYTE_FREE;
			end
		end
		// Cold restart frees everything; warm restart simply never asserts it
		if (bus.cold_restart) begin
			for (int s = 0; s < `MCSC_NUM_SEM; s++) begin
				sem_byte_nxt[s] = `MCSC_BYTE_FREE;
			end
		end
	end

	always_ff @(posedge bus.clock or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			for (int s = 0; s < `MCSC_NUM_SEM; s++) begin
				sem_byte_r[s] <= `MCSC_BYTE_FREE;
			end
		end else begin
			sem_byte_r <= sem_byte_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Owner table, written only by a successful acquire
	always_comb begin
		owner_nxt = owner_r;
		for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
			if (req_take[c]) begin
				owner_nxt[bus.req_sem[c]] = c[`MCSC_CPU_W-1:0];
			end
		end
	end

	always_ff @(posedge bus.clock or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			for (int s = 0; s < `MCSC_NUM_SEM; s++) begin
				owner_r[s] <= '0;
			end
		end else begin
			owner_r <= owner_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Held map follows the bytes bit for bit
	always_comb begin
		held_nxt = held_r;
		for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
			if (req_take[c]) begin
				held_nxt[bus.req_sem[c]] = 1'h1;
			end
			if (req_drop[c]) begin
				held_nxt[bus.req_sem[c]] = 1'h0;
			end
		end
		if (bus.cold_restart) begin
			held_nxt = '0;
		end
	end

	always_ff @(posedge bus.clock or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			held_r <= '0;
		end else begin
			held_r <= held_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answers: registered so that the CPU end sees them a full cycle
	always_comb begin
		rsp_valid_nxt = req_live;
		for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
			if (req_done[c]) begin
				rsp_result_nxt[c] = `MCSC_RES_DONE;
			end else begin
				rsp_result_nxt[c] = `MCSC_RES_DENIED;
			end
		end
	end

	always_ff @(posedge bus.clock or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			rsp_valid_r <= '0;
			for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
				rsp_result_r[c] <= `MCSC_RES_DENIED;
			end
		end else begin
			rsp_valid_r <= rsp_valid_nxt;
			rsp_result_r <= rsp_result_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Every output comes straight from a register
	assign bus.rsp_valid = rsp_valid_r;
	assign bus.rsp_result = rsp_result_r;
	assign held_map = held_r;
endmodule

// File: rtl/mcsc_cpus.sv
`include "mcsc_cfg.svh"
module mcsc_cpus (
	mcsc_if.cpus bus,
	input wire logic [`MCSC_NUM_CPU-1:0] user_req,
	input wire logic [`MCSC_NUM_CPU-1:0] user_acquire,
	input wire logic [`MCSC_NUM_CPU*`MCSC_SEM_W-1:0] user_sem,
	input wire logic user_cold_restart,
	output logic [`MCSC_NUM_CPU-1:0] user_done,
	output logic [`MCSC_NUM_CPU-1:0] result_bit_high,
	output logic [`MCSC_NUM_CPU-1:0] result_bit_low,
	output logic [`MCSC_NUM_CPU-1:0] user_busy
);
	logic [`MCSC_NUM_CPU-1:0] valid_r, valid_nxt, busy_r, busy_nxt;
	logic [`MCSC_NUM_CPU-1:0] acq_r, acq_nxt, done_r, done_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
	mcsc_pkg::mcsc_sem_t sem_r [`MCSC_NUM_CPU];
	mcsc_pkg::mcsc_sem_t sem_nxt [`MCSC_NUM_CPU];
	logic cold_r, cold_nxt;

	////////////////////////////////////////////////////////////////////////
	// Each CPU issues its own request and waits for the answer
	always_comb begin
		valid_nxt = '0;
		busy_nxt = busy_r;
		acq_nxt = acq_r;
		done_nxt = '0;
		hi_nxt = hi_r;
		lo_nxt = lo_r;
		sem_nxt = sem_r;
		cold_nxt = user_cold_restart;
		for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
			if (busy_r[c] && bus.rsp_valid[c]) begin
				busy_nxt[c] = 1'b0;
				done_nxt[c] = 1'b1;
				hi_nxt[c] = bus.rsp_result[c][1];
				lo_nxt[c] = bus.rsp_result[c][0];
			end else if (!busy_r[c] && user_req[c] && !user_cold_restart) begin
				valid_nxt[c] = 1'b1;
				busy_nxt[c] = 1'b1;
				acq_nxt[c] = user_acquire[c];
				sem_nxt[c] = user_sem[c*`MCSC_SEM_W +: `MCSC_SEM_W];
			end
		end
		if (user_cold_restart) begin
			busy_nxt = '0;
		end
	end

	always_ff @(posedge bus.clock or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			valid_r <= '0;
			busy_r <= '0;
			acq_r <= '0;
			done_r <= '0;
			hi_r <= '0;
			lo_r <= '0;
			cold_r <= 1'b0;
			for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
				sem_r[c] <= '0;
			end
		end else begin
			valid_r <= valid_nxt;
			busy_r <= busy_nxt;
			acq_r <= acq_nxt;
			done_r <= done_nxt;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			cold_r <= cold_nxt;
			sem_r <= sem_nxt;
		end
	end

	always_comb begin
		for (int c = 0; c < `MCSC_NUM_CPU; c++) begin
			bus.req_op[c] = acq_r[c] ? mcsc_pkg::MCSC_OP_ACQUIRE : mcsc_pkg::MCSC_OP_RELEASE;
		end
	end
	assign bus.req_valid = valid_r;
	assign bus.req_sem = sem_r;
	assign bus.cold_restart = cold_r;
	assign user_done = done_r;
	assign result_bit_high = hi_r;
	assign result_bit_low = lo_r;
	assign user_busy = busy_r;
endmodule

// File: dv/mcsc_assertions.sv
`include "mcsc_cfg.svh"
module mcsc_assertions (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] req_valid,
	input mcsc_pkg::mcsc_op_e req_op [4],
	input mcsc_pkg::mcsc_sem_t req_sem [4],
	input wire logic [3:0] rsp_valid,
	input mcsc_pkg::mcsc_res_t rsp_result [4],
	input wire logic cold_restart
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// CPU0 asks, CPU1 follows one cycle later on the same semaphore
	sequence s_take0(op);
		req_valid[0] && req_op[0] == op && !cold_restart;
	endsequence
	sequence s_follow1(op);
		rsp_result[0] == 2'h2 && !req_valid[0] && !cold_restart && req_valid[1]
			&& req_op[1] == op && req_sem[1] == $past(req_sem[0]);
	endsequence
	for (genvar c = 0; c < 4; c++) begin : g_cpu
		a_answer_next: assert property (req_valid[c] && !cold_restart |=> rsp_valid[c])
			else $error("request not answered");
		a_no_stray: assert property (rsp_valid[c] |-> $past(req_valid[c]) && !$past(cold_restart))
			else $error("answer without request");
		a_cold_refused: assert property (req_valid[c] && cold_restart |=> !rsp_valid[c])
			else $error("answer during cold restart");
		a_result_code: assert property (rsp_valid[c] |-> rsp_result[c] inside {2'h0, 2'h2})
			else $error("bad result code");
	end
	a_one_winner: assert property (req_valid[0] && req_valid[1] && req_op[0] == req_op[1]
		&& req_op[0] == mcsc_pkg::MCSC_OP_ACQUIRE && req_sem[0] == req_sem[1] && !cold_restart
		|=> !(rsp_result[0] == 2'h2 && rsp_result[1] == 2'h2)) else $error("two winners");
	a_held_denied: assert property (s_take0(mcsc_pkg::MCSC_OP_ACQUIRE)
		##1 s_follow1(mcsc_pkg::MCSC_OP_ACQUIRE) |=> rsp_result[1] == 2'h0)
		else $error("held semaphore granted");
	a_owner_only: assert property (s_take0(mcsc_pkg::MCSC_OP_ACQUIRE)
		##1 s_follow1(mcsc_pkg::MCSC_OP_RELEASE) |=> rsp_result[1] == 2'h0)
		else $error("foreign release accepted");
	a_release_frees: assert property (s_take0(mcsc_pkg::MCSC_OP_RELEASE)
		##1 s_follow1(mcsc_pkg::MCSC_OP_ACQUIRE) |=> rsp_result[1] == 2'h2)
		else $error("released semaphore refused");
endmodule

// File: dv/multi_cpu_semaphore_coordinator_tb.sv
module multi_cpu_semaphore_coordinator_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 0, rst_n = 0, user_cold_restart = 0;
	logic [3:0] user_req = 0, user_acquire = 0, user_done, rbh, rbl, user_busy, eh = 0, el = 0;
	logic [19:0] user_sem = 0;
	logic [31:0] held_map, hm = 0, r = 32'h8A98C1AA;
	int own [32];
	int failures = 0, compares = 0, cycles = 0;
	mcsc_if mcsc_if_inst (.clock(clock), .rst_n(rst_n));
	mcsc_coord mcsc_coord_inst (.bus(mcsc_if_inst), .held_map(held_map));
	mcsc_cpus mcsc_cpus_inst (.bus(mcsc_if_inst), .user_req(user_req),
		.user_acquire(user_acquire), .user_sem(user_sem), .user_cold_restart(user_cold_restart),
		.user_done(user_done), .result_bit_high(rbh), .result_bit_low(rbl), .user_busy(user_busy));
	mcsc_assertions mcsc_assertions_inst (.clock(clock), .rst_n(rst_n),
		.req_valid(mcsc_if_inst.req_valid), .req_op(mcsc_if_inst.req_op),
		.req_sem(mcsc_if_inst.req_sem), .rsp_valid(mcsc_if_inst.rsp_valid),
		.rsp_result(mcsc_if_inst.rsp_result), .cold_restart(mcsc_if_inst.cold_restart));
	initial begin
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	//////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Same-cycle requests are modelled in CPU index order, as arbitrated
	function automatic logic [1:0] model(input int c, input logic a, input logic [4:0] s);
		if (hm[s] && own[s] != c)
			return 2'h0;
		own[s] = c;
		hm[s] = a;
		return 2'h2;
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %0t: value %h, expected %h", $time, seen, exp);
		end
	endtask
	task step(input logic [3:0] m, input logic [3:0] a, input logic [19:0] s);
		@(posedge clock);
		user_req <= m;
		user_acquire <= a;
		user_sem <= s;
	endtask
	// Second batch goes one cycle after the first, so it sees the first's effect
	task run(input logic [3:0] m0, a0, input logic [19:0] s0, input logic [3:0] m1, a1,
		input logic [19:0] s1);
		step(m0, a0, s0);
		step(m1, a1, s1);
		step(4'h0, 4'h0, 20'h0);
		repeat (3) @(posedge clock);
		for (int i = 0; i < 4; i++)
			if (m0[i]) {eh[i], el[i]} = model(i, a0[i], s0[i*5+:5]);
		for (int i = 0; i < 4; i++)
			if (m1[i]) {eh[i], el[i]} = model(i, a1[i], s1[i*5+:5]);
		chk({24'h0, rbh, rbl}, {24'h0, eh, el});
		chk(held_map, hm);
	endtask
	task print_verdict;
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		run(4'h1, 4'h1, 20'hFFFFF, 4'h2, 4'h2, 20'hFFFFF);
		run(4'h1, 4'h1, 20'hFFFFF, 4'h2, 4'h0, 20'hFFFFF);
		run(4'h1, 4'h0, 20'hFFFFF, 4'h2, 4'h2, 20'hFFFFF);
		run(4'hF, 4'hF, 20'h0, 4'h0, 4'h0, 20'h0);
		for (int n = 0; n < 400; n++) begin
			r = xs(r);
			// Few semaphore numbers, so collisions between CPUs are common
			run(r[3:0], r[7:4], r[27:8] & 20'h8C631, 4'h0, 4'h0, 20'h0);
		end
		repeat (4) @(posedge clock);
		chk(held_map, hm);
		user_cold_restart <= 1'b1;
		@(posedge clock);
		user_cold_restart <= 1'b0;
		repeat (2) @(posedge clock);
		hm = 0;
		chk(held_map, hm);
		print_verdict();
	end
endmodule
